/* File: hw/hlc_line_codec.sv */
`default_nettype none
module hlc_line_codec
   import hlc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Encoder side
   input wire logic encClk,
   input wire logic nrzIn,
   output logic posLineOut,
   output logic negLineOut,
   // Decoder side
   input wire logic decClk,
   input wire logic posLineIn,
   input wire logic negLineIn,
   output logic nrzOut,
   output logic regenClk,
   output logic hdb3Error,
   // Alarm
   input wire logic zeroCountWindowStrobe,
   output logic allOnesAlarm
);
   // ==============================
   // State
   typedef struct packed {
      logic [1:0] ctrl;
      logic errSticky;
      logic [31:0] rdata;
      hlc_sym_t [ENC_DEPTH-1:0] encSh;
      logic encPar;
      logic encLastPos;
      logic posOut;
      logic negOut;
      logic curMark;
      logic curPos;
      logic [DEC_DEPTH-1:0] decSh;
      logic decLastPos;
      logic [1:0] sameCnt;
      logic nrz;
      logic err;
      logic [1:0] zeroCnt;
      hlc_alm_t alm;
      logic alarm;
      logic regen;
   } hlc_state_t;

   hlc_state_t q, d;

   logic [PIN_COUNT-1:0] pinLvl, pinRise, pinFall;
   logic hdb3Sel, loopSel;
   logic encRise, encFall, decRise, strobeFall, strobeLvl;
   logic decPosIn, decNegIn, decMark, decPol, isViol;
   logic subst, wrEn, rdSetup, mapped;
   hlc_sym_t outSym;

   function automatic logic addr_mapped(input logic [11:0] a);
      addr_mapped = (a == ADDR_CTRL) || (a == ADDR_STATUS);
   endfunction

   // ==============================
   // Pin synchronisers
   // Encode and decode clocks are edge-detected apart and never gate each other
   hlc_pin_sync #(
      .W(PIN_COUNT)
   ) u_sync (
      .core_clk(core_clk),
      .rstn(rstn),
      .pinIn({zeroCountWindowStrobe, negLineIn, posLineIn, decClk, nrzIn, encClk}),
      .pinLvl(pinLvl),
      .pinRise(pinRise),
      .pinFall(pinFall)
   );

   assign hdb3Sel = q.ctrl[CTRL_HDB3];
   assign loopSel = q.ctrl[CTRL_LOOP];
   assign encRise = pinRise[PIN_ENC_CLK];
   assign encFall = pinFall[PIN_ENC_CLK];
   assign decRise = pinRise[PIN_DEC_CLK];
   assign strobeFall = pinFall[PIN_STROBE];
   assign strobeLvl = pinLvl[PIN_STROBE];

   // Loop mode swaps the line inputs for the encoder outputs
   assign decPosIn = loopSel ? q.posOut : pinLvl[PIN_POS];
   assign decNegIn = loopSel ? q.negOut : pinLvl[PIN_NEG];
   // Either input counts as a mark; polarity only compared, so swap is harmless
   assign decMark = decPosIn | decNegIn;
   assign decPol = decPosIn;
   // Same polarity as the last mark is a substitution violation
   assign isViol = hdb3Sel && decMark && (decPol == q.decLastPos);

   // Four zeros in a row: new bit zero and three older plain spaces
   assign subst = hdb3Sel && !pinLvl[PIN_NRZ] && !q.encSh[0].mark
                  && !q.encSh[1].mark && !q.encSh[2].mark;
   assign outSym = q.encSh[ENC_DEPTH-1];

   assign mapped = addr_mapped(paddr);
   assign wrEn = psel && penable && pwrite && mapped;
   assign rdSetup = psel && !penable && !pwrite;

   // ==============================
   // Next state
   always_comb begin
      d = q;
      // Register access, zero wait states
      if (wrEn && paddr == ADDR_CTRL) begin
         d.ctrl = pwdata[1:0];
      end
      if (rdSetup) begin
         d.rdata = '0;
         if (paddr == ADDR_CTRL) begin
            d.rdata[1:0] = q.ctrl;
         end else if (paddr == ADDR_STATUS) begin
            d.rdata[STAT_ALARM] = q.alarm;
            d.rdata[STAT_ERR] = q.err;
            d.rdata[STAT_ERR_STICKY] = q.errSticky;
            d.rdata[STAT_ENC_POL] = q.encLastPos;
            d.rdata[STAT_DEC_POL] = q.decLastPos;
         end
      end
      if (wrEn && paddr == ADDR_STATUS && pwdata[STAT_ERR_STICKY]) begin
         d.errSticky = 1'b0;
      end

      // Encoder input stage: capture on falling edge
      if (encFall) begin
         d.encSh = {q.encSh[ENC_DEPTH-2:0], hlc_sym_t'{mark: pinLvl[PIN_NRZ], viol: 1'b0}};
         if (subst) begin
            // Fourth zero becomes a violation mark
            d.encSh[0] = hlc_sym_t'{mark: 1'b1, viol: 1'b1};
            // First zero becomes a balancing mark when marks since last
            // violation are even; second and third stay spaces
            d.encSh[ENC_DEPTH-1].mark = ~q.encPar;
            d.encPar = 1'b0;
         end else if (pinLvl[PIN_NRZ]) begin
            d.encPar = ~q.encPar;
         end
      end

      // Encoder output stage: polarity decided at rising edge
      if (encRise) begin
         d.curMark = outSym.mark;
         if (outSym.mark) begin
            // Normal marks alternate, violations repeat polarity
            d.curPos = outSym.viol ? q.encLastPos : ~q.encLastPos;
            d.encLastPos = d.curPos;
         end
      end
      // Return-to-zero pulses follow the clock high phase
      d.posOut = pinLvl[PIN_ENC_CLK] && d.curMark && d.curPos;
      d.negOut = pinLvl[PIN_ENC_CLK] && d.curMark && !d.curPos;

      // Decoder: sample on decode rising edge
      if (decRise) begin
         // Violation removes itself and the balancing mark three back
         d.nrz = q.decSh[DEC_DEPTH-1] && !isViol;
         d.decSh = {q.decSh[DEC_DEPTH-2:0], decMark && !isViol};
         d.err = 1'b0;
         if (decMark) begin
            d.decLastPos = decPol;
            if (decPol == q.decLastPos) begin
               d.sameCnt = (q.sameCnt == ZERO_MAX) ? ZERO_MAX : 2'(q.sameCnt + 2'h1);
               // Third mark of one polarity flags an error, HDB3 only
               d.err = hdb3Sel && (q.sameCnt >= SAME_LIMIT);
            end else begin
               d.sameCnt = 2'h1;
            end
         end
      end
      if (!hdb3Sel) begin
         d.err = 1'b0;
      end
      // Set wins over a software clear in the same cycle
      if (d.err) begin
         d.errSticky = 1'b1;
      end

      // Decoded zero counter gated by the window strobe
      if (!strobeLvl) begin
         d.zeroCnt = '0;
      end else if (decRise && !d.nrz && q.zeroCnt != ZERO_MAX) begin
         d.zeroCnt = 2'(q.zeroCnt + 2'h1);
      end

      // Alarm steps only on strobe falling edge
      if (strobeFall) begin
         if (q.zeroCnt > ZERO_LIMIT) begin
            d.alm = ALM_CLEAR;
         end else begin
            case (q.alm)
               ALM_CLEAR: d.alm = ALM_ONE_LOW;
               ALM_ONE_LOW: d.alm = ALM_RAISED;
               ALM_RAISED: d.alm = ALM_RAISED;
               default: d.alm = ALM_CLEAR;
            endcase
         end
      end
      d.alarm = (d.alm == ALM_RAISED);

      // Clock regeneration source follows the loop selection
      d.regen = loopSel ? (q.posOut | q.negOut)
                        : (pinLvl[PIN_POS] | pinLvl[PIN_NEG]);
   end

   // ==============================
   // Registers
   // Polarity trackers start at a fixed value
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         q <= '0;
         q.ctrl <= CTRL_RESET;
         q.encLastPos <= POL_RESET;
         q.decLastPos <= POL_RESET;
         q.alm <= ALM_CLEAR;
      end else begin
         q <= d;
      end
   end

   // ==============================
   // Outputs
   assign prdata = q.rdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign posLineOut = q.posOut;
   assign negLineOut = q.negOut;
   assign nrzOut = q.nrz;
   assign regenClk = q.regen;
   assign hdb3Error = q.err;
   assign allOnesAlarm = q.alarm;

   // ==============================
   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   sequence sLowWindow;
      strobeFall && (q.zeroCnt <= ZERO_LIMIT);
   endsequence

   sequence sTwoLowWindows;
      (q.alm == ALM_ONE_LOW) and sLowWindow;
   endsequence

   sequence sSubstStep;
      encFall && subst;
   endsequence

   sequence sPlainOut;
      encRise && outSym.mark && !outSym.viol;
   endsequence

   a_alarm_raise: assert property (
      sTwoLowWindows |=> allOnesAlarm
   ) else $error("alarm not raised after two low windows");

   a_alarm_clear: assert property (
      strobeFall && (q.zeroCnt > ZERO_LIMIT) |=> !allOnesAlarm
   ) else $error("alarm not cleared after busy window");

   a_alarm_edge_only: assert property (
      $changed(allOnesAlarm) |-> $past(strobeFall)
   ) else $error("alarm changed away from strobe fall");

   a_error_cause: assert property (
      $rose(hdb3Error) |-> $past(decRise) && $past(q.sameCnt) >= SAME_LIMIT
   ) else $error("error without three same marks");

   a_regen_normal: assert property (
      !loopSel ##1 !loopSel |-> regenClk == $past(pinLvl[PIN_POS] | pinLvl[PIN_NEG])
   ) else $error("regen clock not ORed line inputs");

   a_regen_loop: assert property (
      loopSel ##1 loopSel |-> regenClk == $past(q.posOut | q.negOut)
   ) else $error("regen clock not ORed encoder outputs");

   a_rz_low: assert property (
      !pinLvl[PIN_ENC_CLK] |=> !posLineOut && !negLineOut
   ) else $error("line output high in clock low phase");

   a_one_polarity: assert property (
      !(posLineOut && negLineOut)
   ) else $error("both line outputs high");

   a_ami_no_error: assert property (
      !hdb3Sel |=> !hdb3Error
   ) else $error("error raised in AMI mode");

   a_counter_clear: assert property (
      !strobeLvl |=> q.zeroCnt == 2'h0
   ) else $error("zero counter not cleared");

   a_subst_viol: assert property (
      encFall && subst |=> q.encSh[0].mark && q.encSh[0].viol && !q.encPar
   ) else $error("fourth zero not a violation");

   a_viol_repeat: assert property (
      encRise && outSym.mark && outSym.viol |=> q.curPos == $past(q.encLastPos)
   ) else $error("violation polarity wrong");

   a_subst_first: assert property (
      sSubstStep |=> q.encSh[ENC_DEPTH-1].mark == !$past(q.encPar)
   ) else $error("first zero of run not balanced");

   a_subst_spaces: assert property (
      sSubstStep |=> !q.encSh[1].mark && !q.encSh[2].mark
   ) else $error("middle zeros of run not spaces");

   a_nrz_capture: assert property (
      encFall && !subst |=> q.encSh[0].mark == $past(pinLvl[PIN_NRZ])
   ) else $error("input bit not captured at falling edge");

   a_ami_plain: assert property (
      encFall && !hdb3Sel |=> !q.encSh[0].viol
   ) else $error("violation inserted in AMI mode");

   a_launch_rise: assert property (
      $rose(posLineOut || negLineOut) |-> $past(encRise)
   ) else $error("line pulse launched away from clock rise");

   a_mark_alternate: assert property (
      sPlainOut |=> q.curPos != $past(q.encLastPos)
   ) else $error("plain mark did not alternate");

   a_dec_sample: assert property (
      $changed(q.decLastPos) |-> $past(decRise)
   ) else $error("decoder polarity changed away from clock rise");

   a_nrz_update: assert property (
      $changed(nrzOut) |-> $past(decRise)
   ) else $error("decoded data changed away from clock rise");

   a_loop_feed: assert property (
      loopSel && decRise && q.posOut |=> q.decLastPos
   ) else $error("loop did not feed encoder output to decoder");
endmodule
`default_nettype wire

/* File: hw/hlc_pin_sync.sv */
`default_nettype none
module hlc_pin_sync
   import hlc_pkg::*;
#(
   parameter int W = PIN_COUNT
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Asynchronous pins
   input wire logic [W-1:0] pinIn,
   // Synchronised levels and edges
   output logic [W-1:0] pinLvl,
   output logic [W-1:0] pinRise,
   output logic [W-1:0] pinFall
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] lvl;
      logic [W-1:0] prev;
   } hlc_sync_t;

   hlc_sync_t q, d;

   // First stage feeds only the second; edges use stages two and three
   always_comb begin
      d = q;
      d.meta = pinIn;
      d.lvl = q.meta;
      d.prev = q.lvl;
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign pinLvl = q.lvl;
   assign pinRise = q.lvl & ~q.prev;
   assign pinFall = ~q.lvl & q.prev;
endmodule
`default_nettype wire

/* File: inc/hlc_pkg.sv */
// Function
// - Alarm high after two low-zero windows
// - Alarm clears when window saw over two zeros
// - Alarm updates only at strobe falling edge
// - Error on three same-polarity marks, HDB3 only
// - Normal mode: regen clock is ORed inputs
// - Loop mode: regen clock is ORed outputs
// - Pos input positive mark, inputs swappable
// - Decoder samples inputs at decode rising edge
// - Normal mode: encoder, decoder independent
// - Loop mode: encoder outputs feed decoder
// - Loop latency seven periods
// - Two return-to-zero outputs, one per polarity
// - Pulses launch at rise, last high phase
// - Encoder lags NRZ input four periods
// - Decoder lags line input three periods
// - Zeros become spaces, four-zero runs substituted
// - Ones alternate polarity except violations
// - First zero space or balancing mark
// - Second and third zeros always spaces
// - Fourth zero is same-polarity violation
// - NRZ captured at encode clock falling edge
// - Code select high HDB3, low AMI
// - Strobe low clears zero counter, high counts
`default_nettype none
package hlc_pkg;
   // ==============================
   // Pipeline depths and limits
   localparam int ENC_DEPTH = 4;
   localparam int DEC_DEPTH = 3;
   localparam logic [1:0] ZERO_LIMIT = 2'h2;
   localparam logic [1:0] ZERO_MAX = 2'h3;
   localparam logic [1:0] SAME_LIMIT = 2'h2;
   // ==============================
   // Pin sync vector positions
   localparam int PIN_COUNT = 6;
   localparam int PIN_ENC_CLK = 0;
   localparam int PIN_NRZ = 1;
   localparam int PIN_DEC_CLK = 2;
   localparam int PIN_POS = 3;
   localparam int PIN_NEG = 4;
   localparam int PIN_STROBE = 5;
   // ==============================
   // Register map (byte addresses)
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam int CTRL_HDB3 = 0;
   localparam int CTRL_LOOP = 1;
   localparam int STAT_ALARM = 0;
   localparam int STAT_ERR = 1;
   localparam int STAT_ERR_STICKY = 2;
   localparam int STAT_ENC_POL = 3;
   localparam int STAT_DEC_POL = 4;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   localparam logic [0:0] POL_RESET = 1'h0;
   // ==============================
   // Types
   typedef enum logic [1:0] {
      ALM_CLEAR = 2'b00,
      ALM_ONE_LOW = 2'b01,
      ALM_RAISED = 2'b11
   } hlc_alm_t;
   typedef struct packed {
      logic mark;
      logic viol;
   } hlc_sym_t;
endpackage
`default_nettype wire

/* File: tb/hlc_line_codec_bench.sv */
`default_nettype none
module hlc_line_codec_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import hlc_pkg::*;
   // ==============================
   // Signals
   localparam logic [63:0] PAT = 64'h80C0_0920_B000_1740;
   logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic encClk, nrzIn, posLineOut, negLineOut, decClk, posLineIn, negLineIn;
   logic nrzOut, regenClk, hdb3Error, zeroCountWindowStrobe, allOnesAlarm;
   logic swap, hdb, errSeen, lastPol, haveM, haveV, lastV;
   logic [1:0] lineMode;
   logic tx [0:1023];
   int badCount, checks, k, base, src, cnt;

   hlc_line_codec hlc_line_codec_i (.core_clk(core_clk), .rstn(rstn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .encClk(encClk), .nrzIn(nrzIn), .posLineOut(posLineOut),
      .negLineOut(negLineOut), .decClk(decClk), .posLineIn(posLineIn),
      .negLineIn(negLineIn), .nrzOut(nrzOut), .regenClk(regenClk),
      .hdb3Error(hdb3Error), .zeroCountWindowStrobe(zeroCountWindowStrobe),
      .allOnesAlarm(allOnesAlarm));
   hlc_line_partner hlc_line_partner_i (.encClk(encClk), .posLineOut(posLineOut),
      .negLineOut(negLineOut), .lineMode(lineMode), .swap(swap), .decClk(decClk),
      .posLineIn(posLineIn), .negLineIn(negLineIn));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // Link clock offset so its edges fall between core clock edges
   initial begin
      encClk = 1'b0;
      #3;
      forever #80 encClk = ~encClk;
   end
   // ==============================
   // Tasks
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      checks++;
      if (seen !== exp) begin
         badCount++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Bus cycles stall the bit stream, so stream checks restart afterwards
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      base = k;
   endtask

   task automatic cfg(input logic [1:0] c, input logic [1:0] lm, input logic sw);
      apb(1'b1, ADDR_CTRL, {30'h0, c});
      lineMode <= lm;
      swap <= sw;
      hdb = c[0];
      haveV = 1'b0;
   endtask

   // One encode period: drive a bit, then judge line, clock and decoded data
   task automatic period();
      logic p, n, m, b, full, expV;
      int z, j;
      tx[k] = (src == 0) ? PAT[63 - (k % 64)] : (src == 1);
      @(posedge encClk);
      @(posedge core_clk) nrzIn <= tx[k];
      repeat (6) @(negedge core_clk);
      p = posLineOut;
      n = negLineOut;
      m = p | n;
      repeat (3) @(negedge core_clk);
      chk(regenClk, m);
      repeat (4) @(negedge core_clk);
      errSeen |= hdb3Error;
      if (lineMode != 2'h1 && k >= base + 8) begin
         chk(nrzOut, tx[k-7]);
         chk(hdb3Error, 1'b0);
      end
      if (k >= base + 24) begin
         b = tx[k-4];
         z = 0;
         while (z < 16 && !tx[k-4-z]) z++;
         j = (z == 0) ? 0 : (z - 1) % 4 + 1;
         full = hdb && !b;
         for (int i = 1; i <= 4; i++) full &= !tx[k-4-j+i];
         expV = full && j == 4;
         chk(p & n, 1'b0);
         if (b) chk(m, 1'b1);
         else if (!full || j == 2 || j == 3) chk(m, 1'b0);
         else if (j == 4) chk(m, 1'b1);
         else if (haveV) chk(m, !cnt[0]);
         if (m && haveM) chk(p == lastPol, expV);
         if (m && expV && haveV) chk(p, !lastV);
      end
      if (m) begin
         if (haveM && p == lastPol) begin
            lastV = p;
            haveV = 1'b1;
            cnt = 0;
         end else begin
            cnt++;
         end
         lastPol = p;
         haveM = 1'b1;
      end
      k++;
   endtask

   // Zeros sent at the window start are decoded inside the window
   task automatic window(input int z, input logic exp);
      logic was;
      was = allOnesAlarm;
      @(posedge core_clk) zeroCountWindowStrobe <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         src = (i < z) ? 2 : 1;
         period();
      end
      chk(allOnesAlarm, was);
      @(posedge core_clk) zeroCountWindowStrobe <= 1'b0;
      src = 1;
      repeat (3) period();
      chk(allOnesAlarm, exp);
   endtask
   // ==============================
   // Tests
   initial begin
      foreach (tx[i]) tx[i] = 1'b0;
      {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
      {nrzIn, zeroCountWindowStrobe, swap, lineMode} = '0;
      {haveM, haveV, lastPol, lastV, errSeen} = '0;
      k = 20;
      base = 20;
      src = 0;
      cnt = 0;
      hdb = 1'b1;
      badCount = 0;
      checks = 0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, {30'h0, CTRL_RESET});
      apb(1'b0, 12'h008, 32'h0);
      chk({err, rd}, 33'h1_0000_0000);
      repeat (128) period();
      cfg(2'h1, 2'h0, 1'b1);
      repeat (64) period();
      cfg(2'h0, 2'h0, 1'b0);
      repeat (64) period();
      cfg(2'h3, 2'h2, 1'b0);
      repeat (64) period();
      src = 1;
      cfg(2'h1, 2'h1, 1'b0);
      errSeen = 1'b0;
      repeat (16) period();
      chk(errSeen, 1'b1);
      cfg(2'h0, 2'h1, 1'b0);
      errSeen = 1'b0;
      repeat (16) period();
      chk(errSeen, 1'b0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[STAT_ERR_STICKY], 1'b1);
      chk(rd[STAT_ERR], 1'b0);
      chk(rd[STAT_ENC_POL], lastPol);
      chk(rd[STAT_DEC_POL], 1'b1);
      apb(1'b1, ADDR_STATUS, 32'h4);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[STAT_ERR_STICKY], 1'b0);
      cfg(2'h1, 2'h0, 1'b0);
      repeat (8) period();
      window(0, 1'b0);
      window(0, 1'b1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[STAT_ALARM], 1'b1);
      window(2, 1'b1);
      window(3, 1'b0);
      window(0, 1'b0);
      wrap_up();
   end

   initial begin
      #300_000;
      badCount++;
      wrap_up();
   end
endmodule
`default_nettype wire

/* File: tb/hlc_line_partner.sv */
`default_nettype none
module hlc_line_partner (
   // Encoder line and clock
   input wire logic encClk,
   input wire logic posLineOut,
   input wire logic negLineOut,
   // Line impairments
   input wire logic [1:0] lineMode,
   input wire logic swap,
   // Toward the decoder
   output logic decClk,
   output logic posLineIn,
   output logic negLineIn
);
   timeunit 1ns;
   timeprecision 100ps;
   logic p;
   logic n;
   // ==============================
   // Recovered clock, delayed so its rise lands mid-pulse; never stopped
   initial decClk = 1'b0;
   always @(encClk) decClk <= #60 encClk;
   // ==============================
   // Line: pass, fold every mark to positive, or mute
   always_comb begin
      p = posLineOut;
      n = negLineOut;
      if (lineMode == 2'h1) begin
         p = posLineOut | negLineOut;
         n = 1'b0;
      end else if (lineMode == 2'h2) begin
         p = 1'b0;
         n = 1'b0;
      end
      posLineIn = swap ? n : p;
      negLineIn = swap ? p : n;
   end
endmodule
`default_nettype wire
